// ---- pkg/tfoc_pkg.sv ----
// Package for the timer force, channel-7 override and counter block
package tfoc_pkg;

	// Channel count and counter width
	localparam int unsigned NUM_CH  = 8;
	localparam int unsigned CNT_W   = 16;

	// Printed offsets are byte offsets but not multiples of four: indices
	localparam logic [7:0] IDX_CH_SELECT    = 8'h00;
	localparam logic [7:0] IDX_FORCE        = 8'h01;
	localparam logic [7:0] IDX_OVR_MASK     = 8'h02;
	localparam logic [7:0] IDX_OVR_DATA     = 8'h03;
	localparam logic [7:0] IDX_CNT_HIGH     = 8'h04;
	localparam logic [7:0] IDX_CNT_LOW      = 8'h05;
	localparam logic [7:0] IDX_CTRL         = 8'h06;
	localparam logic [7:0] IDX_TOGGLE_OVF   = 8'h07;
	localparam logic [7:0] IDX_PIN_DISC     = 8'h2C;
	localparam logic [7:0] IDX_ACTION       = 8'h40;
	localparam logic [7:0] IDX_CMP_BASE     = 8'h41;
	localparam logic [7:0] IDX_INT_STAT     = 8'h50;
	localparam logic [7:0] IDX_INT_MASK     = 8'h51;
	localparam logic [7:0] IDX_PRESCALE     = 8'h52;
	localparam logic [7:0] IDX_CH_FLAGS     = 8'h53;

	// Control register fields
	localparam int unsigned CTRL_EN_BIT      = 7;
	localparam int unsigned CTRL_SPECIAL_BIT = 0;

	// Interrupt status layout
	localparam int unsigned IRQ_OVF_BIT = 0;
	localparam int unsigned IRQ_CH7_BIT = 1;
	localparam int unsigned IRQ_W       = 2;

	// Reset values
	localparam logic [7:0]       RST_BYTE  = 8'h00;
	localparam logic [CNT_W-1:0] RST_CNT   = 16'h0000;
	localparam logic [15:0]      RST_ACT   = 16'h0000;
	localparam logic [7:0]       RST_PRESC = 8'h00;
	localparam logic [31:0]      FORCE_READ = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hFFFF;

	// Implemented channel mask (unimplemented bits read zero)
	localparam logic [7:0] CH_IMPL = 8'hFF;

	// Output compare pin actions
	typedef enum logic [1:0] {
		TFOC_ACT_NONE,
		TFOC_ACT_TOGGLE,
		TFOC_ACT_CLEAR,
		TFOC_ACT_SET
	} tfoc_act_e;

	// Per-channel view handed to the pin module
	typedef struct packed {
		logic [7:0]  sel_oc;
		logic [7:0]  disc;
		logic [7:0]  tog_ovf;
		logic [7:0]  ovr_mask;
		logic [7:0]  ovr_data;
		logic [15:0] action;
	} tfoc_cfg_s;

	typedef struct packed {
		logic [7:0] force_hit;
		logic [7:0] match_hit;
		logic       ovf;
	} tfoc_evt_s;

endpackage : tfoc_pkg

// ---- rtl/tfoc_pins.sv ----
// Per-channel output compare pin logic with channel-7 override
`timescale 1ns/1ps
module tfoc_pins
	import tfoc_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	// Configuration and events
	input  wire tfoc_pkg::tfoc_cfg_s cfg,
	input  wire tfoc_pkg::tfoc_evt_s evt,
	// Pin state
	output logic [7:0]             pin_ff
);
	logic       ch7_event;
	logic [7:0] nxt_pin;

	// Channel-7 event: its compare match or force, or overflow with its toggle bit
	assign ch7_event = (cfg.sel_oc[7] & (evt.match_hit[7] | evt.force_hit[7]))
		| (evt.ovf & cfg.tog_ovf[7]);

	// One copy of the pin decision per channel
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			tfoc_act_e act;
			logic      hit;
			logic      drive;
			assign act   = tfoc_act_e'(cfg.action[2*g +: 2]);
			assign hit   = evt.force_hit[g] | evt.match_hit[g];
			assign drive = cfg.sel_oc[g] & ~cfg.disc[g];
			always_comb begin
				nxt_pin[g] = pin_ff[g];
				if (drive) begin
					// Override beats toggle, toggle beats forced or matched action
					if (ch7_event && cfg.ovr_mask[g]) begin
						nxt_pin[g] = cfg.ovr_data[g];
					end else if (evt.ovf && cfg.tog_ovf[g]) begin
						nxt_pin[g] = ~pin_ff[g];
					end else if (hit && !(ch7_event && g != 7 &&
						cfg.ovr_mask[7])) begin
						case (act)
							TFOC_ACT_TOGGLE: nxt_pin[g] = ~pin_ff[g];
							TFOC_ACT_CLEAR:  nxt_pin[g] = 1'b0;
							TFOC_ACT_SET:    nxt_pin[g] = 1'b1;
							default:         nxt_pin[g] = pin_ff[g];
						endcase
					end
				end
			end
		end
	endgenerate

	// Pin register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_ff <= RST_BYTE;
		end else if (clk_en) begin
			pin_ff <= nxt_pin & CH_IMPL;
		end
	end

	// Masked override bit follows data on a channel-7 match
	a_ovr_copy: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && cfg.sel_oc[7] && evt.match_hit[7] && cfg.ovr_mask[0]
		&& cfg.sel_oc[0] && !cfg.disc[0] |=> pin_ff[0] == $past(cfg.ovr_data[0]))
		else $error("override data not copied");
	// Disconnected pin never moves, even when masked for override
	a_disc_hold: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && cfg.disc[3] |=> pin_ff[3] == $past(pin_ff[3]))
		else $error("disconnected pin changed");
endmodule : tfoc_pins

// ---- rtl/tfoc_top.sv ----
// Timer force compare, channel-7 override and main counter with APB regs
`timescale 1ns/1ps
module tfoc_top
	import tfoc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Timer port and interrupt
	output logic      [7:0]  timer_pins,
	output logic             irq
);
	// Registers
	logic [7:0]       ch_select_ff;
	logic [7:0]       force_bits_ff;
	logic [7:0]       ch7_override_mask_ff;
	logic [7:0]       ch7_override_data_ff;
	logic [7:0]       toggle_on_overflow_ff;
	logic [7:0]       pin_disconnect_ff;
	logic [7:0]       ctrl_ff;
	logic [15:0]      action_ff;
	logic [7:0]       prescale_ff;
	logic [7:0]       presc_cnt_ff;
	logic [CNT_W-1:0] main_counter_ff;
	logic [CNT_W-1:0] cmp_ff [NUM_CH];
	logic [7:0]       ch_flags_ff;
	logic [IRQ_W-1:0] int_stat_ff;
	logic [IRQ_W-1:0] int_mask_ff;
	logic [31:0]      prdata_ff;
	logic             pready_ff;
	logic             pslverr_ff;
	logic             irq_ff;
	logic             tick_ff;
	logic             ovf_ff;
	logic [7:0]       match_ff;

	// Bus decode
	logic       acc;
	logic       wr;
	logic       rd;
	logic       addr_ok;
	logic [9:0] idx;
	logic [31:0] nxt_prdata;
	logic [7:0] wbyte;
	logic       special;
	logic       run;
	tfoc_cfg_s  cfg;
	tfoc_evt_s  evt;

	// Word index; only aligned addresses write, reads ignore paddr[1:0]
	assign idx     = paddr[11:2];
	assign addr_ok = (paddr[1:0] == 2'b00);
	assign acc     = psel & penable & ~pready_ff & clk_en;
	assign wr      = acc & pwrite & addr_ok;
	assign rd      = acc & ~pwrite;
	assign wbyte   = pwdata[7:0];
	assign special = ctrl_ff[CTRL_SPECIAL_BIT];
	assign run     = ctrl_ff[CTRL_EN_BIT];

	// Answer one cycle after access phase starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= FORCE_READ;
		end else if (clk_en) begin
			pready_ff  <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~addr_ok;
			prdata_ff  <= rd ? nxt_prdata : FORCE_READ;
		end
	end

	// Read mux; unmapped words read zero
	always_comb begin
		nxt_prdata = FORCE_READ;
		if (idx == 10'(IDX_CH_SELECT)) begin
			nxt_prdata[7:0] = ch_select_ff;
		end else if (idx == 10'(IDX_FORCE)) begin
			nxt_prdata = FORCE_READ;
		end else if (idx == 10'(IDX_OVR_MASK)) begin
			nxt_prdata[7:0] = ch7_override_mask_ff;
		end else if (idx == 10'(IDX_OVR_DATA)) begin
			nxt_prdata[7:0] = ch7_override_data_ff;
		end else if (idx == 10'(IDX_CNT_HIGH)) begin
			nxt_prdata[15:0] = main_counter_ff;
		end else if (idx == 10'(IDX_CNT_LOW)) begin
			nxt_prdata[7:0] = main_counter_ff[7:0];
		end else if (idx == 10'(IDX_CTRL)) begin
			nxt_prdata[7:0] = ctrl_ff;
		end else if (idx == 10'(IDX_TOGGLE_OVF)) begin
			nxt_prdata[7:0] = toggle_on_overflow_ff;
		end else if (idx == 10'(IDX_PIN_DISC)) begin
			nxt_prdata[7:0] = pin_disconnect_ff;
		end else if (idx == 10'(IDX_ACTION)) begin
			nxt_prdata[15:0] = action_ff;
		end else if (idx == 10'(IDX_INT_STAT)) begin
			nxt_prdata[IRQ_W-1:0] = int_stat_ff;
		end else if (idx == 10'(IDX_INT_MASK)) begin
			nxt_prdata[IRQ_W-1:0] = int_mask_ff;
		end else if (idx == 10'(IDX_PRESCALE)) begin
			nxt_prdata[7:0] = prescale_ff;
		end else if (idx == 10'(IDX_CH_FLAGS)) begin
			nxt_prdata[7:0] = ch_flags_ff;
		end else if (idx >= 10'(IDX_CMP_BASE) &&
			idx < 10'(IDX_CMP_BASE) + 10'(NUM_CH)) begin
			nxt_prdata[15:0] = cmp_ff[3'(idx - 10'(IDX_CMP_BASE))];
		end
	end

	// Plain configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch_select_ff          <= RST_BYTE;
			ch7_override_mask_ff  <= RST_BYTE;
			ch7_override_data_ff  <= RST_BYTE;
			toggle_on_overflow_ff <= RST_BYTE;
			pin_disconnect_ff     <= RST_BYTE;
			ctrl_ff               <= RST_BYTE;
			action_ff             <= RST_ACT;
			prescale_ff           <= RST_PRESC;
			int_mask_ff           <= '0;
		end else if (wr) begin
			// Unimplemented channel bits masked off on write
			if (idx == 10'(IDX_CH_SELECT))
				ch_select_ff <= wbyte & CH_IMPL;
			if (idx == 10'(IDX_OVR_MASK))
				ch7_override_mask_ff <= wbyte & CH_IMPL;
			if (idx == 10'(IDX_OVR_DATA))
				ch7_override_data_ff <= wbyte & CH_IMPL;
			if (idx == 10'(IDX_TOGGLE_OVF))
				toggle_on_overflow_ff <= wbyte & CH_IMPL;
			if (idx == 10'(IDX_PIN_DISC))
				pin_disconnect_ff <= wbyte & CH_IMPL;
			if (idx == 10'(IDX_CTRL))
				ctrl_ff <= wbyte;
			if (idx == 10'(IDX_ACTION))
				action_ff <= pwdata[15:0];
			if (idx == 10'(IDX_PRESCALE))
				prescale_ff <= wbyte;
			if (idx == 10'(IDX_INT_MASK))
				int_mask_ff <= pwdata[IRQ_W-1:0];
		end
	end

	// Compare value array, one word per channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CH; i++)
				cmp_ff[i] <= RST_CNT;
		end else if (wr && idx >= 10'(IDX_CMP_BASE) &&
			idx < 10'(IDX_CMP_BASE) + 10'(NUM_CH)) begin
			cmp_ff[3'(idx - 10'(IDX_CMP_BASE))] <= pwdata[15:0];
		end
	end

	// Force strobe lives one cycle only, so nothing is held to read back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_bits_ff <= RST_BYTE;
		end else if (clk_en) begin
			force_bits_ff <= (wr && idx == 10'(IDX_FORCE)) ?
				(wbyte & CH_IMPL) : RST_BYTE;
		end
	end

	// Prescaler: tick every prescale_ff+1 cycles while running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_cnt_ff <= RST_PRESC;
			tick_ff      <= 1'b0;
		end else if (clk_en) begin
			// Prescaler not reset by counter writes, hence drift
			if (!run) begin
				presc_cnt_ff <= RST_PRESC;
				tick_ff      <= 1'b0;
			end else if (presc_cnt_ff >= prescale_ff) begin
				presc_cnt_ff <= RST_PRESC;
				tick_ff      <= 1'b1;
			end else begin
				presc_cnt_ff <= presc_cnt_ff + 8'h01;
				tick_ff      <= 1'b0;
			end
		end
	end

	// Main counter: word write loads in special mode only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_counter_ff <= RST_CNT;
			ovf_ff          <= 1'b0;
		end else if (clk_en) begin
			ovf_ff <= tick_ff && main_counter_ff == CNT_ALL_ONES;
			if (wr && special && idx == 10'(IDX_CNT_HIGH)) begin
				main_counter_ff <= pwdata[15:0];
			end else if (wr && special && idx == 10'(IDX_CNT_LOW)) begin
				main_counter_ff[7:0] <= wbyte;
			end else if (tick_ff) begin
				main_counter_ff <= main_counter_ff + 16'h0001;
			end
		end
	end

	// Compare match detect, registered once per tick
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_match
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					match_ff[g] <= 1'b0;
				end else if (clk_en) begin
					match_ff[g] <= tick_ff & ch_select_ff[g] &
						(main_counter_ff == cmp_ff[g]);
				end
			end
		end
	endgenerate

	// Channel flags: match sets unless forced; write one clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch_flags_ff <= RST_BYTE;
		end else if (clk_en) begin
			ch_flags_ff <= (ch_flags_ff & ~((wr && idx == 10'(IDX_CH_FLAGS))
				? wbyte : RST_BYTE)) | (match_ff & ~force_bits_ff);
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_ff <= '0;
			irq_ff      <= 1'b0;
		end else if (clk_en) begin
			int_stat_ff[IRQ_OVF_BIT] <= ovf_ff |
				(int_stat_ff[IRQ_OVF_BIT] & ~(wr &&
				idx == 10'(IDX_INT_STAT) && pwdata[IRQ_OVF_BIT]));
			int_stat_ff[IRQ_CH7_BIT] <= match_ff[7] |
				(int_stat_ff[IRQ_CH7_BIT] & ~(wr &&
				idx == 10'(IDX_INT_STAT) && pwdata[IRQ_CH7_BIT]));
			irq_ff <= |(int_stat_ff & int_mask_ff);
		end
	end

	// Configuration bundle for the pin logic
	assign cfg.sel_oc   = ch_select_ff;
	assign cfg.disc     = pin_disconnect_ff;
	assign cfg.tog_ovf  = toggle_on_overflow_ff;
	assign cfg.ovr_mask = ch7_override_mask_ff;
	assign cfg.ovr_data = ch7_override_data_ff;
	assign cfg.action   = action_ff;
	assign evt.force_hit = force_bits_ff;
	assign evt.match_hit = match_ff;
	assign evt.ovf       = ovf_ff;

	// Pin action unit
	tfoc_pins u_pins (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.cfg     (cfg),
		.evt     (evt),
		.pin_ff  (timer_pins)
	);

	// Registered bus outputs
	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq     = irq_ff;

	// Force read returns zero
	a_force_zero: assert property (@(posedge pclk) disable iff (!presetn)
		rd && idx == 10'(IDX_FORCE) && clk_en |=> prdata == 32'h0)
		else $error("force register read nonzero");
	// Forced channel never flags even with match
	a_force_noflag: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && force_bits_ff[0] && !ch_flags_ff[0] |=> !ch_flags_ff[0])
		else $error("forced channel set flag");
	// Force strobe lasts one cycle
	a_force_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && force_bits_ff != 8'h00 && !wr |=> force_bits_ff == 8'h00)
		else $error("force strobe held");
	// Normal-mode write leaves counter unchanged
	a_cnt_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && wr && !special && !tick_ff |=>
		main_counter_ff == $past(main_counter_ff))
		else $error("counter written in normal mode");
	// Counter climbs by one on tick
	a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && tick_ff && !wr |=>
		main_counter_ff == $past(main_counter_ff) + 16'h0001)
		else $error("counter did not step");
	// Wrap raises overflow next cycle
	a_cnt_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && tick_ff && main_counter_ff == 16'hFFFF && !wr
		##1 clk_en |-> ovf_ff && main_counter_ff == 16'h0000)
		else $error("wrap without overflow");
	// Toggle on overflow flips a pin that no channel-7 event overrides
	a_tog_ovf: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ovf_ff && toggle_on_overflow_ff[4] && ch_select_ff[4]
		&& !pin_disconnect_ff[4] && !(ch7_override_mask_ff[4] &&
		(toggle_on_overflow_ff[7] || (ch_select_ff[7] &&
		(match_ff[7] || force_bits_ff[7]))))
		|=> timer_pins[4] != $past(timer_pins[4]))
		else $error("overflow toggle missed");
	// Capture-mode channel pin stays put
	a_cap_hold: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !ch_select_ff[3] |=> timer_pins[3] == $past(timer_pins[3]))
		else $error("capture pin driven");
endmodule : tfoc_top

// ---- tb/tfoc_top_tb.sv ----
// Self-checking testbench for the timer force, override and counter block
`timescale 1ns/1ps
module tfoc_top_tb;
	import tfoc_pkg::*;

	// Design connections
	logic        pclk;
	logic        presetn;
	logic        clk_en;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  timer_pins;
	logic        irq;
	// Bench bookkeeping
	int          mismatches;
	int          n_tests;
	int          cyc;
	logic [31:0] rd;
	logic        err;

	tfoc_top tfoc_top_i (
		.pclk       (pclk),
		.presetn    (presetn),
		.clk_en     (clk_en),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.timer_pins (timer_pins),
		.irq        (irq)
	);

	// 40 MHz bus clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Hang guard: whole run is a few hundred cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready without assuming its latency
	task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task wr(input logic [7:0] idx, input logic [31:0] d);
		xfer({2'b00, idx, 2'b00}, 1'b1, d);
	endtask : wr

	task rdr(input logic [7:0] idx);
		xfer({2'b00, idx, 2'b00}, 1'b0, 32'h0000_0000);
	endtask : rdr

	// Let a force strobe reach the pins before looking
	task settle;
		repeat (3) @(posedge pclk);
		#1;
	endtask : settle

	task results;
		$display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	initial begin
		presetn = 1'b0;
		clk_en  = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
		mismatches = 0;
		n_tests    = 0;
		cyc        = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk(timer_pins, 32'h0000_0000);
		chk(irq, 32'h0000_0000);

		// Register access, upper bits and refusals
		rdr(IDX_OVR_MASK);
		chk(rd, 32'h0000_0000);
		wr(IDX_OVR_MASK, 32'hFFFF_FFA5);
		rdr(IDX_OVR_MASK);
		chk(rd, 32'h0000_00A5);
		wr(IDX_OVR_DATA, 32'h0000_005A);
		rdr(IDX_OVR_DATA);
		chk(rd, 32'h0000_005A);
		// Force with every channel still capturing: strobe reads zero
		wr(IDX_FORCE, 32'h0000_00FF);
		rdr(IDX_FORCE);
		chk(rd, 32'h0000_0000);
		settle();
		chk(timer_pins, 32'h0000_0000);
		wr(8'hFF, 32'h1234_5678);
		rdr(8'hFF);
		chk(rd, 32'h0000_0000);
		xfer(12'h009, 1'b1, 32'h0000_00FF);
		chk(err, 32'h0000_0001);
		// Unaligned write must not land
		rdr(IDX_OVR_MASK);
		chk(rd, 32'h0000_00A5);
		chk(err, 32'h0000_0000);
		$display("test registers done");

		// Counter writes only land in special mode
		wr(IDX_CNT_HIGH, 32'h0000_1234);
		rdr(IDX_CNT_HIGH);
		chk(rd, 32'h0000_0000);
		wr(IDX_CTRL, 32'h0000_0001);
		wr(IDX_CNT_HIGH, 32'h0000_1234);
		rdr(IDX_CNT_HIGH);
		chk(rd, 32'h0000_1234);
		wr(IDX_CNT_LOW, 32'h0000_0056);
		rdr(IDX_CNT_HIGH);
		chk(rd, 32'h0000_1256);
		$display("test counter writes done");

		// Forced set on channels 0..6, no flags raised
		wr(IDX_CH_SELECT, 32'h0000_00FF);
		wr(IDX_PIN_DISC, 32'h0000_0000);
		wr(IDX_OVR_MASK, 32'h0000_0000);
		wr(IDX_ACTION, 32'h0000_3FFF);
		wr(IDX_FORCE, 32'h0000_007F);
		settle();
		chk(timer_pins, 32'h0000_007F);
		rdr(IDX_CH_FLAGS);
		chk(rd, 32'h0000_0000);
		rdr(IDX_INT_STAT);
		chk(rd, 32'h0000_0000);
		$display("test force done");

		// Channel-7 event: masked bits take data, capture/disconnected hold
		wr(IDX_OVR_DATA, 32'h0000_0000);
		wr(IDX_OVR_MASK, 32'h0000_000F);
		wr(IDX_PIN_DISC, 32'h0000_0008);
		wr(IDX_CH_SELECT, 32'h0000_00FB);
		wr(IDX_FORCE, 32'h0000_0080);
		settle();
		chk(timer_pins, 32'h0000_007C);
		// Event with mask bit 7 set suppresses clears on channels 4..6
		wr(IDX_ACTION, 32'h0000_2AAA);
		wr(IDX_OVR_DATA, 32'h0000_0081);
		wr(IDX_OVR_MASK, 32'h0000_008F);
		wr(IDX_FORCE, 32'h0000_00FF);
		settle();
		chk(timer_pins, 32'h0000_00FD);
		$display("test override done");

		// Wrap from all ones, toggle on overflow, interrupt path
		wr(IDX_OVR_MASK, 32'h0000_0000);
		wr(IDX_CH_SELECT, 32'h0000_0010);
		wr(IDX_TOGGLE_OVF, 32'h0000_0010);
		wr(IDX_PRESCALE, 32'h0000_007F);
		wr(IDX_CNT_HIGH, 32'h0000_FFFF);
		wr(IDX_CTRL, 32'h0000_0081);
		repeat (150) @(posedge pclk);
		wr(IDX_CTRL, 32'h0000_0001);
		settle();
		chk(timer_pins, 32'h0000_00ED);
		rdr(IDX_CNT_HIGH);
		chk(rd, 32'h0000_0000);
		rdr(IDX_INT_STAT);
		chk(rd, 32'h0000_0001);
		chk(irq, 32'h0000_0000);
		wr(IDX_INT_MASK, 32'h0000_0001);
		settle();
		chk(irq, 32'h0000_0001);
		wr(IDX_INT_STAT, 32'h0000_0001);
		settle();
		chk(irq, 32'h0000_0000);
		rdr(IDX_INT_STAT);
		chk(rd, 32'h0000_0000);
		$display("test overflow done");

		// Channel-7 match: pin 0 takes data, pin 7 toggles, flag raised
		wr(IDX_PRESCALE, 32'h0000_0000);
		wr(IDX_TOGGLE_OVF, 32'h0000_0000);
		wr(IDX_CH_SELECT, 32'h0000_0081);
		wr(IDX_OVR_DATA, 32'h0000_0000);
		wr(IDX_OVR_MASK, 32'h0000_0001);
		wr(IDX_ACTION, 32'h0000_4000);
		wr(IDX_CMP_BASE, 32'h0000_0100);
		wr(IDX_CMP_BASE + 8'h07, 32'h0000_0010);
		rdr(IDX_CMP_BASE + 8'h07);
		chk(rd, 32'h0000_0010);
		wr(IDX_CTRL, 32'h0000_0080);
		repeat (30) @(posedge pclk);
		wr(IDX_CTRL, 32'h0000_0000);
		settle();
		chk(timer_pins, 32'h0000_006C);
		rdr(IDX_CH_FLAGS);
		chk(rd, 32'h0000_0080);
		rdr(IDX_INT_STAT);
		chk(rd, 32'h0000_0002);
		chk(irq, 32'h0000_0000);
		wr(IDX_CH_FLAGS, 32'h0000_0080);
		rdr(IDX_CH_FLAGS);
		chk(rd, 32'h0000_0000);
		$display("test compare match done");

		results();
	end

endmodule : tfoc_top_tb
